/* verilog/sgc_defs.svh */
// constants of the switch global control register bank
`ifndef SGC_DEFS_SVH
`define SGC_DEFS_SVH

// register indices, byte address is four times the index
`define SGC_IDX_IDENT      6'h00
`define SGC_IDX_GCR1       6'h02

// identity and start register fields
`define SGC_B_START        0
`define SGC_IDENT_WMASK    16'h0001

// global control one fields
`define SGC_B_PASS_ALL     15
`define SGC_B_TX_FC        13
`define SGC_B_RX_FC        12
`define SGC_B_LEN_CHK      11
`define SGC_B_AGE_EN       10
`define SGC_B_FAST_AGE     9
`define SGC_B_BACKOFF      8
`define SGC_B_LARGE        4
`define SGC_B_ING_FC       3
`define SGC_B_PASS_FC      3
`define SGC_B_LC_AGE       0
`define SGC_GCR1_RST       16'h3410
`define SGC_GCR1_WMASK     16'hbf19

// frame length limits in bytes
`define SGC_LEN_FIELD_MAX  16'h05dc
`define SGC_LEN_STD_MAX    16'h07d0
`define SGC_LEN_LARGE_MAX  16'h0800

// timing
`define SGC_CLK_NS         20
`define SGC_FAST_AGE_NS    800000
`define SGC_NORM_AGE_S     300
`define SGC_FAST_AGE_CYC   (`SGC_FAST_AGE_NS / `SGC_CLK_NS)
`define SGC_NS_PER_S       64'd1000000000
`define SGC_NORM_AGE_CYC   (`SGC_NS_PER_S / `SGC_CLK_NS * `SGC_NORM_AGE_S)

`endif

/* verilog/sgc_pkg.sv */
// types of the switch global control register bank
package sgc_pkg;

    // aging engine modes
    typedef enum logic [1:0] {
        SGC_AGE_OFF  = 2'b00,
        SGC_AGE_NORM = 2'b01,
        SGC_AGE_FAST = 2'b10
    } sgc_age_t;

    // description of one received frame
    typedef struct packed {
        logic [15:0] len_type;
        logic [15:0] act_len;
        logic        bad;
        logic        pause;
    } sgc_frm_t;

    // verdict on one received frame
    typedef struct packed {
        logic done;
        logic drop;
        logic pause_apply;
    } sgc_verdict_t;

endpackage

/* verilog/sgc_bank.sv */
// switch identity, start and global control registers
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defs.svh"

// Contract
// - read-only family, chip and revision fields
// - pass-all forwards every non-pause frame while the switch runs, bad included
// - transmit flow control off means no pause
// - receive flow control off ignores pause
// - drop frames with mismatched short length field
// - aging runs only while aging enabled
// - fast-age bit shortens aging to 800 us
// - bit 8 selects aggressive half-duplex back-off
// - ingress excess drops frame, or if bit 3 set sends pause when tx flow is on
// - large enable accepts 2K, else 2000 limit
// - pass-flow-control bit forwards pause frames
// - link drop triggers one fast age cycle
// - any link loss ages out all addresses
module sgc_bank
    import sgc_pkg::*;
#(
    parameter logic [7:0]  FAMILY_ID    = 8'h5a,  // arbitrary value
    parameter logic [3:0]  CHIP_ID      = 4'h3,   // arbitrary value
    parameter logic [2:0]  REV_ID       = 3'h2,   // arbitrary value
    parameter logic [33:0] FAST_AGE_CYC = 34'(`SGC_FAST_AGE_CYC),
    parameter logic [33:0] NORM_AGE_CYC = 34'(`SGC_NORM_AGE_CYC)
) (
    input  wire logic         CORE_CLK,     // system clock
    input  wire logic         RST_N,        // sync reset, low
    input  wire logic [7:0]   WB_ADR_I,     // byte address
    input  wire logic [31:0]  WB_DAT_I,     // write data
    output logic      [31:0]  WB_DAT_O,     // read data
    input  wire logic [3:0]   WB_SEL_I,     // byte selects
    input  wire logic         WB_WE_I,      // write strobe
    input  wire logic         WB_CYC_I,     // bus cycle
    input  wire logic         WB_STB_I,     // slave select
    output logic              WB_ACK_O,     // acknowledge
    input  wire logic [1:0]   LINK_UP,      // port link pins
    input  wire logic         FRM_VALID,    // frame info valid
    input  wire sgc_frm_t     FRM_INFO,     // frame info
    input  wire logic         ING_OVER,     // ingress limit hit
    input  wire logic         CONGEST,      // egress congestion
    output logic              SWITCH_RUN,   // switching enabled
    output logic              PASS_ALL,     // pass all frames
    output logic              TX_FC_EN,     // tx flow control
    output logic              RX_FC_EN,     // rx flow control
    output logic              AGGR_BACKOFF, // aggressive back-off
    output logic              LARGE_PKT_EN, // 2K frames allowed
    output logic              AGE_TICK,     // age one round
    output logic              AGE_FLUSH,    // age out all entries
    output logic              FRM_DONE,     // verdict valid
    output logic              FRM_DROP,     // frame dropped
    output logic              PAUSE_APPLY,  // obey pause frame
    output logic              PAUSE_SEND,   // send pause frame
    output logic              ING_DROP      // drop excess frame
);

    // ---------------------------------------------------------
    // register bank and wishbone slave
    // ---------------------------------------------------------
    logic        start_q;       // start bit
    logic        start_d;
    logic [15:0] gcr1_q;        // global control one
    logic [15:0] gcr1_d;
    logic        ack_q;         // bus acknowledge
    logic        ack_d;
    logic [31:0] rdat_q;        // read data
    logic [31:0] rdat_d;
    logic [15:0] ident_m;       // identity word after a write

    // byte-lane merge under the writable mask
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [15:0] wdat,
        input logic [1:0]  sel,
        input logic [15:0] wmask
    );
        logic [15:0] lane;
        lane = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
        return (old & ~lane) | (wdat & lane);
    endfunction

    // register index from the byte address
    function automatic logic [5:0] reg_idx(input logic [7:0] a);
        return a[7:2];
    endfunction

    // identity word as read by software
    logic [15:0] ident_w;
    assign ident_w = {FAMILY_ID, CHIP_ID, REV_ID, start_q};

    // next state of the bank
    always_comb begin
        start_d = start_q;
        gcr1_d  = gcr1_q;
        ack_d   = 1'b0;
        rdat_d  = rdat_q;
        // only the start bit of the identity word is writable
        ident_m = merge16({15'h0000, start_q}, WB_DAT_I[15:0],
            WB_SEL_I[1:0], `SGC_IDENT_WMASK);
        // one-cycle ack, dropped the cycle after it was given
        if (WB_CYC_I && WB_STB_I && !ack_q) begin
            ack_d  = 1'b1;
            rdat_d = 32'h0000_0000;
            case (reg_idx(WB_ADR_I))
                `SGC_IDX_IDENT: begin
                    rdat_d = {16'h0000, ident_w};
                    if (WB_WE_I) begin
                        // only the start bit is writable
                        start_d = ident_m[`SGC_B_START];
                    end
                end
                `SGC_IDX_GCR1: begin
                    rdat_d = {16'h0000, gcr1_q};
                    if (WB_WE_I) begin
                        // reserved bits never stored
                        gcr1_d = merge16(gcr1_q, WB_DAT_I[15:0],
                            WB_SEL_I[1:0],
                            `SGC_GCR1_WMASK);
                    end
                end
                // unmapped: ack with zero data, no effect
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // bank registers
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            start_q <= 1'b0;
            gcr1_q  <= `SGC_GCR1_RST;
            ack_q   <= 1'b0;
            rdat_q  <= 32'h0000_0000;
        end else begin
            start_q <= start_d;
            gcr1_q  <= gcr1_d;
            ack_q   <= ack_d;
            rdat_q  <= rdat_d;
        end
    end

    // level controls straight from register bits
    assign WB_ACK_O     = ack_q;
    assign WB_DAT_O     = rdat_q;
    assign SWITCH_RUN   = start_q;
    assign PASS_ALL     = gcr1_q[`SGC_B_PASS_ALL];
    assign TX_FC_EN     = gcr1_q[`SGC_B_TX_FC];
    assign RX_FC_EN     = gcr1_q[`SGC_B_RX_FC];
    assign AGGR_BACKOFF = gcr1_q[`SGC_B_BACKOFF];
    assign LARGE_PKT_EN = gcr1_q[`SGC_B_LARGE];

    // ---------------------------------------------------------
    // link pin synchroniser and link-loss detection
    // ---------------------------------------------------------
    logic [1:0] lnk_s1_q;       // first sync stage
    logic [1:0] lnk_s2_q;       // second sync stage
    logic [1:0] lnk_old_q;      // previous synced level
    logic [1:0] lnk_old_d;
    logic       lnk_drop;       // some port went down

    // edge detect reads only the second stage
    always_comb begin
        lnk_old_d = lnk_s2_q;
        lnk_drop  = |(lnk_old_q & ~lnk_s2_q);
    end

    // sync and history registers
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            lnk_s1_q  <= 2'h0;
            lnk_s2_q  <= 2'h0;
            lnk_old_q <= 2'h0;
        end else begin
            lnk_s1_q  <= LINK_UP;
            lnk_s2_q  <= lnk_s1_q;
            lnk_old_q <= lnk_old_d;
        end
    end

    // ---------------------------------------------------------
    // aging engine
    // ---------------------------------------------------------
    sgc_age_t    age_st_q;      // aging mode
    sgc_age_t    age_st_d;
    logic [33:0] age_cnt_q;     // cycles into period
    logic [33:0] age_cnt_d;
    logic        lc_pend_q;     // one fast round owed
    logic        lc_pend_d;
    logic        tick_q;        // age round pulse
    logic        tick_d;
    logic        flush_q;       // flush pulse
    logic        flush_d;
    logic [33:0] age_end;       // current period length

    // next state of the aging engine
    always_comb begin
        age_st_d  = age_st_q;
        age_cnt_d = age_cnt_q + 34'h1;
        lc_pend_d = lc_pend_q;
        tick_d    = 1'b0;
        flush_d   = lnk_drop;
        age_end   = NORM_AGE_CYC;
        // link loss owes one fast round
        if (lnk_drop && gcr1_q[`SGC_B_LC_AGE]) begin
            lc_pend_d = 1'b1;
        end
        case (age_st_q)
            SGC_AGE_OFF: begin
                age_cnt_d = 34'h0;
                if (start_q && gcr1_q[`SGC_B_AGE_EN]) begin
                    age_st_d = SGC_AGE_NORM;
                end
            end
            SGC_AGE_NORM, SGC_AGE_FAST: begin
                // fast bit or owed round picks short period
                if (gcr1_q[`SGC_B_FAST_AGE] || lc_pend_q) begin
                    age_st_d = SGC_AGE_FAST;
                    age_end  = FAST_AGE_CYC;
                end else begin
                    age_st_d = SGC_AGE_NORM;
                end
                if (age_cnt_q >= age_end - 34'h1) begin
                    // round complete, owed round paid
                    age_cnt_d = 34'h0;
                    tick_d    = 1'b1;
                    lc_pend_d = lnk_drop &&
                        gcr1_q[`SGC_B_LC_AGE];
                end
                if (!start_q || !gcr1_q[`SGC_B_AGE_EN]) begin
                    age_st_d  = SGC_AGE_OFF;
                    age_cnt_d = 34'h0;
                    tick_d    = 1'b0;
                end
            end
            default: begin
                age_st_d  = SGC_AGE_OFF;
                age_cnt_d = 34'h0;
            end
        endcase
    end

    // aging registers
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            age_st_q  <= SGC_AGE_OFF;
            age_cnt_q <= 34'h0;
            lc_pend_q <= 1'b0;
            tick_q    <= 1'b0;
            flush_q   <= 1'b0;
        end else begin
            age_st_q  <= age_st_d;
            age_cnt_q <= age_cnt_d;
            lc_pend_q <= lc_pend_d;
            tick_q    <= tick_d;
            flush_q   <= flush_d;
        end
    end

    assign AGE_TICK  = tick_q;
    assign AGE_FLUSH = flush_q;

    // ---------------------------------------------------------
    // frame verdict and flow control requests
    // ---------------------------------------------------------
    sgc_verdict_t vrd_q;        // registered verdict
    sgc_verdict_t vrd_d;
    logic         psend_q;      // pause request pulse
    logic         psend_d;
    logic         idrop_q;      // ingress drop pulse
    logic         idrop_d;
    logic         len_bad;      // length field mismatch
    logic         too_long;     // over size limit
    logic         faulty;       // any error on frame

    // next verdict and requests
    always_comb begin
        // short length field must match real length
        len_bad = gcr1_q[`SGC_B_LEN_CHK] &&
            (FRM_INFO.len_type < `SGC_LEN_FIELD_MAX) &&
            (FRM_INFO.len_type != FRM_INFO.act_len);
        // size limit follows the large-packet bit
        too_long = gcr1_q[`SGC_B_LARGE] ?
            (FRM_INFO.act_len > `SGC_LEN_LARGE_MAX) :
            (FRM_INFO.act_len > `SGC_LEN_STD_MAX);
        faulty = (FRM_INFO.bad || len_bad || too_long) &&
            !gcr1_q[`SGC_B_PASS_ALL];
        vrd_d.done = FRM_VALID;
        vrd_d.drop = FRM_VALID && (!start_q || faulty ||
            (FRM_INFO.pause &&
            !gcr1_q[`SGC_B_PASS_FC]));
        vrd_d.pause_apply = FRM_VALID && start_q &&
            FRM_INFO.pause && gcr1_q[`SGC_B_RX_FC];
        // pause only when transmit flow control is on
        psend_d = start_q && gcr1_q[`SGC_B_TX_FC] && (CONGEST ||
            (ING_OVER && gcr1_q[`SGC_B_ING_FC]));
        idrop_d = start_q && ING_OVER &&
            !gcr1_q[`SGC_B_ING_FC];
    end

    // verdict registers
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            vrd_q   <= '0;
            psend_q <= 1'b0;
            idrop_q <= 1'b0;
        end else begin
            vrd_q   <= vrd_d;
            psend_q <= psend_d;
            idrop_q <= idrop_d;
        end
    end

    assign FRM_DONE    = vrd_q.done;
    assign FRM_DROP    = vrd_q.drop;
    assign PAUSE_APPLY = vrd_q.pause_apply;
    assign PAUSE_SEND  = psend_q;
    assign ING_DROP    = idrop_q;

endmodule
`default_nettype wire

/* testbench/sgc_bank_monitor.sv */
// port assertions of the switch global control bank
`timescale 1ns/1ps
`default_nettype none
module sgc_bank_monitor
    import sgc_pkg::*;
(
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_ACK_O,
    input wire logic [1:0]  LINK_UP,
    input wire logic        FRM_VALID,
    input wire sgc_frm_t    FRM_INFO,
    input wire logic        ING_OVER,
    input wire logic        CONGEST,
    input wire logic        SWITCH_RUN,
    input wire logic        PASS_ALL,
    input wire logic        TX_FC_EN,
    input wire logic        RX_FC_EN,
    input wire logic        LARGE_PKT_EN,
    input wire logic        AGE_TICK,
    input wire logic        AGE_FLUSH,
    input wire logic        FRM_DROP,
    input wire logic        PAUSE_APPLY,
    input wire logic        PAUSE_SEND,
    input wire logic        ING_DROP
);
    // one clock domain, reset disables all
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // new bus request at a quiet edge
    wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    AST_ACK: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus ack timing wrong");
    AST_ID: assert property (WB_ACK_O && $past(WB_ADR_I) == 8'h00 |->
        WB_DAT_O[15:1] == {8'h5a, 4'h3, 3'h2}) else $error("ident wrong");
    AST_RSV: assert property (WB_ACK_O && $past(WB_ADR_I) == 8'h08 |->
        (WB_DAT_O & 32'hffff40e6) == 32'h0) else $error("reserved set");
    AST_IDLE: assert property (FRM_VALID && !SWITCH_RUN |=>
        FRM_DROP && !PAUSE_APPLY) else $error("idle switch passed frame");
    AST_PASS: assert property (FRM_VALID && SWITCH_RUN && PASS_ALL &&
        !FRM_INFO.pause |=> !FRM_DROP) else $error("pass-all dropped");
    AST_LARGE: assert property (FRM_VALID && SWITCH_RUN && !PASS_ALL &&
        FRM_INFO.act_len > (LARGE_PKT_EN ? 16'h0800 : 16'h07d0) |=>
        FRM_DROP) else $error("long frame kept");
    AST_RXFC: assert property (FRM_VALID && !RX_FC_EN |=> !PAUSE_APPLY)
        else $error("pause obeyed while rx flow off");
    AST_TXFC: assert property (!TX_FC_EN |=> !PAUSE_SEND)
        else $error("pause sent while tx flow off");
    AST_ING: assert property (SWITCH_RUN && TX_FC_EN && ING_OVER &&
        !CONGEST |=> PAUSE_SEND != ING_DROP) else $error("ingress excess");
    AST_FLUSH: assert property ($fell(LINK_UP[0]) || $fell(LINK_UP[1])
        |-> ##[1:6] AGE_FLUSH) else $error("no flush on link loss");
    // main scenarios reached
    CV_DROP: cover property (FRM_VALID ##1 FRM_DROP);
    CV_TICK: cover property (AGE_TICK);
    CV_FLUSH: cover property (AGE_FLUSH);
endmodule
`default_nettype wire

/* testbench/sgc_bank_test.sv */
// random and corner tests of the global control bank
`timescale 1ns/1ps
`default_nettype none
module sgc_bank_test
    import sgc_pkg::*;
;
    localparam int FA = 20;  // short fast period
    localparam int NA = 60;  // short normal period
    localparam logic [31:0] IDW = {16'h0, 8'h5a, 4'h3, 3'h2, 1'b0};
    logic        clk = 1'b0, rst_n = 1'b0, we = 1'b0, cyc = 1'b0;
    logic        stb = 1'b0, fv = 1'b0, ing = 1'b0, cong = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0]  sel = 4'h0;
    logic [1:0]  link = 2'h0;
    sgc_frm_t    fi = 34'h0;
    logic        ack, run, pal, txf, rxf, agg, lrg, tick, fl;
    logic        dn, dr, pap, psd, idr, r, f, t;
    logic [31:0] rs = 32'h0c3c0101;  // xorshift state
    logic [15:0] c;                   // control shadow
    int          mismatches = 0, comparisons = 0, cn = 0, n, k;
    // clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cn++;
        if (cn > 30000) begin
            mismatches++;
            finish_test();
        end
    end
    sgc_bank #(.FAST_AGE_CYC(34'h14), .NORM_AGE_CYC(34'h3c)) dut (
        .CORE_CLK(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_ACK_O(ack), .LINK_UP(link), .FRM_VALID(fv),
        .FRM_INFO(fi), .ING_OVER(ing), .CONGEST(cong), .SWITCH_RUN(run),
        .PASS_ALL(pal), .TX_FC_EN(txf), .RX_FC_EN(rxf),
        .AGGR_BACKOFF(agg), .LARGE_PKT_EN(lrg), .AGE_TICK(tick),
        .AGE_FLUSH(fl), .FRM_DONE(dn), .FRM_DROP(dr), .PAUSE_APPLY(pap),
        .PAUSE_SEND(psd), .ING_DROP(idr));
    task automatic finish_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // compare seen against expected
    task automatic chk(input string s, input logic [31:0] v, e);
        comparisons++;
        if (v !== e) begin
            mismatches++;
            $display("FAIL %s exp %h seen %h", s, e, v);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // expected {drop, apply, pause send, ingress drop}
    function automatic logic [3:0] fx(input sgc_frm_t x, input logic i, g);
        logic lb, tl;
        lb = c[11] && x.len_type < 16'h05dc && x.len_type != x.act_len;
        tl = x.act_len > (c[4] ? 16'h0800 : 16'h07d0);
        return {!r || ((x.bad || lb || tl) && !c[15]) || (x.pause && !c[3]),
                r && x.pause && c[12], r && c[13] && (g || (i && c[3])),
                r && i && !c[3]};
    endfunction
    // one classic wishbone cycle, waits for ack
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [15:0] d);
        adr <= a;
        we <= w;
        wdat <= {16'h0, d};
        sel <= 4'h3;
        cyc <= 1'b1;
        stb <= 1'b1;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    // one random frame with flow inputs, corner lengths mixed in
    task automatic frame();
        sgc_frm_t x;
        logic [3:0] e;
        rs = xs(rs);
        x.act_len = (rs[3:2] == 2'h0) ? 16'h07d0 +
            {10'h0, rs[4], rs[4], 2'h0, rs[1:0]} : {4'h0, rs[27:16]};
        x.len_type = rs[5] ? x.act_len : {5'h0, rs[15:5]};
        x.bad = rs[28] & rs[29];
        x.pause = rs[30];
        e = fx(x, rs[31], rs[6] & rs[7]);
        fi <= x;
        fv <= 1'b1;
        ing <= rs[31];
        cong <= rs[6] & rs[7];
        @(posedge clk);
        fv <= 1'b0;
        ing <= 1'b0;
        cong <= 1'b0;
        #1;
        chk("done", dn, 1'b1);
        chk("drop", dr, e[3]);
        chk("apply", pap, e[2]);
        chk("psend", psd, e[1]);
        chk("idrop", idr, e[0]);
        @(posedge clk);
    endtask
    // cycles between two age ticks
    task automatic gap();
        while (tick !== 1'b1) @(posedge clk);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(8'h00, 1'b0, 16'h0);
        chk("ident", q, IDW);
        wb(8'h08, 1'b0, 16'h0);
        chk("ctl_rst", q, 32'h3410);
        r = 1'b0;
        c = 16'h3410;
        for (k = 0; k < 8; k++) frame();
        wb(8'h04, 1'b1, 16'hffff);
        wb(8'h04, 1'b0, 16'h0);
        chk("unmapped", q, 32'h0);
        wb(8'h08, 1'b1, 16'hffff);
        wb(8'h08, 1'b0, 16'h0);
        chk("ctl_rsv", q, 32'hbf19);
        wb(8'h00, 1'b1, 16'hffff);
        wb(8'h00, 1'b0, 16'h0);
        chk("ident_ro", q, IDW | 32'h1);
        for (k = 0; k < 400; k++) begin
            if (k % 16 == 0) begin
                rs = xs(rs);
                r = rs[16] | rs[17];
                c = rs[15:0] & 16'hbf19;
                wb(8'h00, 1'b1, {15'h0, r});
                wb(8'h08, 1'b1, rs[15:0]);
                chk("levels", {run, pal, txf, rxf, agg, lrg},
                    {r, c[15], c[13], c[12], c[8], c[4]});
            end
            frame();
        end
        wb(8'h00, 1'b1, 16'h0001);
        wb(8'h08, 1'b1, 16'h0600);
        gap();
        gap();
        chk("fast_gap", n, FA);
        wb(8'h08, 1'b1, 16'h0400);
        gap();
        gap();
        chk("norm_gap", n, NA);
        wb(8'h08, 1'b1, 16'h0000);
        f = 1'b0;
        repeat (150) @(posedge clk) f = f | tick;
        chk("age_off", f, 1'b0);
        wb(8'h08, 1'b1, 16'h0401);
        for (k = 0; k < 2; k++) begin
            link[k] <= 1'b1;
            repeat (8) @(posedge clk);
            link[k] <= 1'b0;
            f = 1'b0;
            t = 1'b0;
            n = 0;
            do begin
                @(posedge clk);
                n++;
                f = f | fl;
                t = t | tick;
            end while (!(f && t) && n < 200);
            chk("flush", f, 1'b1);
            chk("lc_fast", n <= FA + 8, 1'b1);
            gap();
            chk("lc_norm", n, NA);
        end
        finish_test();
    end
endmodule
bind sgc_bank sgc_bank_monitor mon (.*);
`default_nettype wire
